/* File: lsj_consts.vh */
// constants for the logic, string and jump decoder
`ifndef LSJ_CONSTS_VH
`define LSJ_CONSTS_VH

// ********************************************************
// opcode patterns (upper bits with width/direction bits stripped, or whole bytes) and modrm field values
// ********************************************************
`define OP_XOR_RM_HI     6'h0C
`define OP_IMM_GRP_HI    7'h40
`define OP_XOR_ACC_HI    7'h1A
`define OP_SMOVE_HI      7'h52
`define OP_SCMP_HI       7'h53
`define OP_SSCAN_HI      7'h57
`define OP_SLOAD_HI      7'h56
`define OP_SSTORE_HI     7'h55
`define OP_PIN_HI        7'h36
`define OP_POUT_HI       7'h37
`define OP_REP_HI        7'h79
`define OP_REP_PLAIN     8'hF2
`define OP_JMP_SHORT     8'hEB
`define OP_JMP_NEAR      8'hE9
`define OP_JMP_FAR       8'hEA
`define OP_GRP_FF        8'hFF
`define REG_XOR          3'h6
`define REG_JMP_IND      3'h4
`define REG_JMP_FAR_IND  3'h5
`define MOD_REG          2'h3

// ********************************************************
// instruction classes
// ********************************************************
`define CL_NONE          4'h0
`define CL_XOR_RM        4'h1
`define CL_XOR_IMM       4'h2
`define CL_XOR_ACC       4'h3
`define CL_SMOVE         4'h4
`define CL_SCMP          4'h5
`define CL_SSCAN         4'h6
`define CL_SLOAD         4'h7
`define CL_SSTORE        4'h8
`define CL_PIN           4'h9
`define CL_POUT          4'hA
`define CL_JMP_DIR       4'hB
`define CL_JMP_IND       4'hC
`define CL_JMP_FAR_IND   4'hD

// ********************************************************
// clock counts
// ********************************************************
`define CLK_XOR_REG      16'h0003
`define CLK_XOR_MEM      16'h000A
`define CLK_XIMM_REG     16'h0004
`define CLK_XIMM_MEM     16'h0010
`define CLK_XACC_B       16'h0003
`define CLK_XACC_W       16'h0004
`define CLK_SMOVE        16'h000E
`define CLK_SCMP         16'h0016
`define CLK_SSCAN        16'h000F
`define CLK_SLOAD        16'h000C
`define CLK_SSTORE       16'h000A
`define CLK_PORT         16'h000E
`define CLK_JMP_DIR      16'h000E
`define CLK_JMP_IND_REG  16'h000B
`define CLK_JMP_IND_MEM  16'h0011
`define CLK_JMP_FAR_IND  16'h001A
`define RB_SCMP          16'h0005
`define RB_SSCAN         16'h0005
`define RB_SLOAD         16'h0006
`define RB_SSTORE        16'h0006
`define RB_SMOVE         16'h0008
`define RB_PORT          16'h0008
`define RI_SCMP          16'h0016
`define RI_SSCAN         16'h000F
`define RI_SLOAD         16'h000B
`define RI_SSTORE        16'h0009
`define RI_SMOVE         16'h0008
`define RI_PORT          16'h0008
`define WORD_XFER_ADD    16'h0004

`endif

/* File: op_classifier.v */
// combinational opcode classifier for the decoder
`timescale 1ns/10ps
`default_nettype none

module op_classifier (
   input wire [7:0] op,         // first opcode byte
   input wire [7:0] modrm,      // second byte
   output reg [3:0] cls,        // instruction class
   output wire wide,            // width bit
   output wire dir,             // direction bit
   output wire mem_op           // modrm selects memory
);
`include "lsj_consts.vh"

   assign wide = op[0];
   assign dir = op[1];
   assign mem_op = (modrm[7:6] != `MOD_REG);

   always @* begin
      cls = `CL_NONE;
      if (op[7:2] == `OP_XOR_RM_HI) begin
         cls = `CL_XOR_RM;
      end else if (op[7:1] == `OP_XOR_ACC_HI) begin
         cls = `CL_XOR_ACC;
      end else if (op[7:1] == `OP_IMM_GRP_HI && modrm[5:3] == `REG_XOR) begin
         cls = `CL_XOR_IMM;
      end else begin
         case (op[7:1])
            `OP_SMOVE_HI: cls = `CL_SMOVE;
            `OP_SCMP_HI: cls = `CL_SCMP;
            `OP_SSCAN_HI: cls = `CL_SSCAN;
            `OP_SLOAD_HI: cls = `CL_SLOAD;
            `OP_SSTORE_HI: cls = `CL_SSTORE;
            `OP_PIN_HI: cls = `CL_PIN;
            `OP_POUT_HI: cls = `CL_POUT;
            default: cls = `CL_NONE;
         endcase
         if (op == `OP_JMP_SHORT || op == `OP_JMP_NEAR || op == `OP_JMP_FAR) begin
            cls = `CL_JMP_DIR;
         end
         if (op == `OP_GRP_FF && modrm[5:3] == `REG_JMP_IND) begin
            cls = `CL_JMP_IND;
         end
         if (op == `OP_GRP_FF && modrm[5:3] == `REG_JMP_FAR_IND && modrm[7:6] != `MOD_REG) begin
            cls = `CL_JMP_FAR_IND;
         end
      end
   end
endmodule

`default_nettype wire

/* File: clock_counter.v */
// cycle counter that times one decoded instruction
`timescale 1ns/10ps
`default_nettype none

module clock_counter (
   input wire mclk,             // core clock
   input wire arst_n,           // async reset, active low
   input wire load,             // start counting
   input wire [15:0] total,     // cycles to run
   output wire busy,            // instruction still running
   output wire last             // final cycle of instruction
);
   reg [15:0] cnt_q;

   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 16'h0000;
      end else if (load) begin
         cnt_q <= total;
      end else if (cnt_q != 16'h0000) begin
         cnt_q <= cnt_q - 16'h0001;
      end
   end

   assign busy = (cnt_q != 16'h0000);
   assign last = (cnt_q == 16'h0001);
endmodule

`default_nettype wire

/* File: lsj_decoder.v */
// logic, string and jump instruction decoder with clock counts
// ********************************************************
// Functional notes
// - decode three exclusive-or forms with counts
// - single string move takes 14 clocks
// - single string compare takes 22 clocks
// - single string scan takes 15 clocks
// - single string load takes 12 clocks
// - single string store takes 10 clocks
// - single port string input takes 14
// - single port string output takes 14
// - repeat prefix repeats by count register; the z-bit form repeats only compare and scan
// - repeated compare/scan/load/store/move cycle formulas
// - repeated port input/output take 8+8n
// - decode jump forms with their counts
// - narrow bus adds 4 per word transfer, except for jump forms
// ********************************************************
`timescale 1ns/10ps
`default_nettype none

module lsj_decoder (
   input wire mclk,                // core clock, 50 MHz
   input wire arst_n,              // async reset, active low
   input wire byte_valid,          // opcode byte offered by prefetch queue
   input wire [7:0] byte_data,     // opcode byte
   input wire [7:0] next_byte,     // following byte (modrm)
   input wire narrow_bus,          // 8-bit bus variant
   input wire [15:0] count_register, // iteration count
   output wire byte_ready,         // decoder accepts byte
   output reg done,                // one-cycle pulse at instruction end
   output reg [3:0] op_class,      // decoded class
   output reg op_wide,             // word operation
   output reg op_dir,              // direction bit
   output reg op_repeat,           // repeated string operation
   output reg op_repeat_z,         // repeat prefix z bit
   output reg [15:0] op_clocks,    // total clock count
   output reg [15:0] op_iterations // iterations performed
);
`include "lsj_consts.vh"

   // ********************************************************
   // decode
   // ********************************************************
   wire [3:0] cls;
   wire wide;
   wire dir;
   wire mem_op;
   wire busy;
   wire last;
   reg rep_q;
   reg rep_z_q;
   reg [15:0] total_d;
   reg [15:0] xfer_d;

   op_classifier u_cls (
      .op(byte_data),
      .modrm(next_byte),
      .cls(cls),
      .wide(wide),
      .dir(dir),
      .mem_op(mem_op)
   );

   function is_string;
      input [3:0] c;
      begin
         is_string = (c >= `CL_SMOVE) && (c <= `CL_POUT);
      end
   endfunction

   wire is_prefix = (byte_data[7:1] == `OP_REP_HI);
   wire take = byte_valid && !busy;
   wire start = take && !is_prefix;
   wire rep_ok = rep_q && is_string(cls) &&
      (cls == `CL_SCMP || cls == `CL_SSCAN || !rep_z_q);
   wire [15:0] n = count_register;

   assign byte_ready = !busy;

   // ********************************************************
   // clock count
   // ********************************************************
   always @* begin
      total_d = 16'h0001;
      xfer_d = 16'h0000;
      case (cls)
         `CL_XOR_RM: begin
            total_d = mem_op ? `CLK_XOR_MEM : `CLK_XOR_REG;
            xfer_d = mem_op ? 16'h0002 : 16'h0000;
         end
         `CL_XOR_IMM: begin
            total_d = mem_op ? `CLK_XIMM_MEM : `CLK_XIMM_REG;
            xfer_d = mem_op ? 16'h0002 : 16'h0000;
         end
         `CL_XOR_ACC: total_d = wide ? `CLK_XACC_W : `CLK_XACC_B;
         `CL_SMOVE: begin
            total_d = rep_ok ? `RB_SMOVE + `RI_SMOVE * n : `CLK_SMOVE;
            xfer_d = rep_ok ? n + n : 16'h0002;
         end
         `CL_SCMP: begin
            total_d = rep_ok ? `RB_SCMP + `RI_SCMP * n : `CLK_SCMP;
            xfer_d = rep_ok ? n + n : 16'h0002;
         end
         `CL_SSCAN: begin
            total_d = rep_ok ? `RB_SSCAN + `RI_SSCAN * n : `CLK_SSCAN;
            xfer_d = rep_ok ? n : 16'h0001;
         end
         `CL_SLOAD: begin
            total_d = rep_ok ? `RB_SLOAD + `RI_SLOAD * n : `CLK_SLOAD;
            xfer_d = rep_ok ? n : 16'h0001;
         end
         `CL_SSTORE: begin
            total_d = rep_ok ? `RB_SSTORE + `RI_SSTORE * n : `CLK_SSTORE;
            xfer_d = rep_ok ? n : 16'h0001;
         end
         `CL_PIN, `CL_POUT: begin
            total_d = rep_ok ? `RB_PORT + `RI_PORT * n : `CLK_PORT;
            xfer_d = rep_ok ? n : 16'h0001;
         end
         `CL_JMP_DIR: total_d = `CLK_JMP_DIR;
         `CL_JMP_IND: begin
            total_d = mem_op ? `CLK_JMP_IND_MEM : `CLK_JMP_IND_REG;
            xfer_d = mem_op ? 16'h0001 : 16'h0000;
         end
         `CL_JMP_FAR_IND: begin
            total_d = `CLK_JMP_FAR_IND;
            xfer_d = 16'h0002;
         end
         default: total_d = 16'h0001;
      endcase
      if (narrow_bus && wide && cls != `CL_JMP_IND && cls != `CL_JMP_FAR_IND &&
         cls != `CL_JMP_DIR) begin
         total_d = total_d + `WORD_XFER_ADD * xfer_d;
      end
      if (total_d == 16'h0000) begin
         total_d = 16'h0001;
      end
   end

   clock_counter u_cnt (
      .mclk(mclk),
      .arst_n(arst_n),
      .load(start),
      .total(total_d),
      .busy(busy),
      .last(last)
   );

   // ********************************************************
   // state
   // ********************************************************
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rep_q <= 1'b0;
         rep_z_q <= 1'b0;
         done <= 1'b0;
         op_class <= 4'h0;
         op_wide <= 1'b0;
         op_dir <= 1'b0;
         op_repeat <= 1'b0;
         op_repeat_z <= 1'b0;
         op_clocks <= 16'h0000;
         op_iterations <= 16'h0000;
      end else begin
         done <= last;
         if (take && is_prefix) begin
            rep_q <= 1'b1;
            rep_z_q <= byte_data[0];
         end else if (start) begin
            rep_q <= 1'b0;
            rep_z_q <= 1'b0;
            op_class <= cls;
            op_wide <= wide;
            op_dir <= dir;
            op_repeat <= rep_ok;
            op_repeat_z <= rep_q && rep_z_q;
            op_clocks <= total_d;
            op_iterations <= rep_ok ? n : (is_string(cls) ? 16'h0001 : 16'h0000);
         end
      end
   end
endmodule

`default_nettype wire

/* File: prefetch_queue_model.sv */
// prefetch queue model offering opcode bytes to the decoder
`timescale 1ns/10ps
`default_nettype none
module prefetch_queue_model (
   input wire logic mclk, // core clock
   input wire logic byte_ready, // decoder accepts
   output logic byte_valid = 1'b0, // byte offered
   output logic [7:0] byte_data = 8'h00, // opcode byte
   output logic [7:0] next_byte = 8'h00 // modrm byte
);
   logic [15:0] q[$];
   logic hit = 1'b0;
   function void push(input logic [7:0] b, input logic [7:0] m);
      q.push_back({b, m});
   endfunction
   // offer held until taken; released lines toggle each cycle
   always @(negedge mclk) begin
      if (hit) void'(q.pop_front());
      hit = 1'b0;
      if (q.size() > 0) begin
         byte_valid = 1'b1;
         {byte_data, next_byte} = q[0];
         hit = byte_ready;
      end else begin
         byte_valid = 1'b0;
         byte_data = ~byte_data;
         next_byte = ~next_byte;
      end
   end
endmodule
`default_nettype wire

/* File: lsj_decoder_sva.sv */
// assertion checker for the instruction decoder
`timescale 1ns/10ps
`default_nettype none
`include "lsj_consts.vh"
module lsj_chk (
   input wire mclk, // clock
   input wire arst_n, // reset
   input wire byte_valid, // offer
   input wire [7:0] byte_data, // byte
   input wire [7:0] next_byte, // modrm
   input wire narrow_bus, // bus width
   input wire [15:0] count_register, // count
   input wire byte_ready, // accept
   input wire done, // end pulse
   input wire [3:0] op_class, // class
   input wire op_repeat, // repeated
   input wire [15:0] op_clocks, // clocks
   input wire [15:0] op_iterations // iterations
);
   wire tk = byte_valid && byte_ready;
   reg [7:0] pfx_q;
   // last accepted prefix byte, zero when none pending
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) pfx_q <= 8'h00;
      else if (tk) pfx_q <= (byte_data[7:1] == 7'h79) ? byte_data : 8'h00;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   chk_xor_acc: assert property (tk && byte_data == 8'h35 |=>
      op_class == `CL_XOR_ACC && op_clocks == 16'h0004) else $error("xor acc count");
   chk_xor_narrow: assert property (tk && byte_data == 8'h31 && next_byte[7:6] != 2'h3 |=>
      op_clocks == ($past(narrow_bus) ? 16'h0012 : 16'h000A)) else $error("xor mem count");
   chk_move_one: assert property (tk && pfx_q != 8'hF2 && byte_data == 8'hA4 |=>
      op_clocks == 16'h000E && op_iterations == 16'h0001 && !op_repeat) else $error("move");
   chk_scan_one: assert property (tk && pfx_q == 8'h00 && byte_data == 8'hAE |=>
      op_clocks == 16'h000F ##15 done) else $error("scan timing");
   chk_store_done: assert property (tk && pfx_q == 8'h00 && byte_data == 8'hAA |->
      ##11 done) else $error("store done");
   chk_rep_cmp: assert property (tk && pfx_q[7:1] == 7'h79 && byte_data == 8'hA6 |=>
      op_repeat && op_clocks == 16'h0005 + 16'h0016 * $past(count_register))
      else $error("rep compare");
   chk_rep_store: assert property (tk && pfx_q == 8'hF2 && byte_data == 8'hAA |=>
      op_clocks == 16'h0006 + 16'h0009 * $past(count_register)
      && op_iterations == $past(count_register)) else $error("rep store");
   chk_rep_port: assert property (tk && pfx_q == 8'hF2 && byte_data[7:1] == 7'h36 && !narrow_bus
      |=> op_clocks == 16'h0008 + 16'h0008 * $past(count_register))
      else $error("rep port");
   chk_jump_time: assert property (tk && byte_data == 8'hEB |=>
      !byte_ready [*8] ##7 byte_ready && done) else $error("jump timing");
   cover property (tk && pfx_q != 8'h00);
   cover property (done && op_repeat);
   cover property (tk && narrow_bus);
endmodule
bind lsj_decoder lsj_chk chk_u (.mclk(mclk), .arst_n(arst_n), .byte_valid(byte_valid),
   .byte_data(byte_data), .next_byte(next_byte), .narrow_bus(narrow_bus),
   .count_register(count_register), .byte_ready(byte_ready), .done(done),
   .op_class(op_class), .op_repeat(op_repeat), .op_clocks(op_clocks),
   .op_iterations(op_iterations));
`default_nettype wire

/* File: lsj_decoder_tb.sv */
// self-checking bench for the instruction decoder
`timescale 1ns/10ps
`default_nettype none
`include "lsj_consts.vh"
module lsj_decoder_tb;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic narrow_bus = 1'b0;
   logic [15:0] count_register = 16'h0000;
   wire byte_valid, byte_ready, done, op_wide, op_dir, op_repeat, op_repeat_z;
   wire [7:0] byte_data, next_byte;
   wire [3:0] op_class;
   wire [15:0] op_clocks, op_iterations;
   logic [39:0] exp_q[$];
   logic [39:0] e;
   logic rep_x;
   int miscompares = 0;
   int comparisons = 0;
   int cyc = 0;
   int n;
   // string ops: opcode, class, single clocks, repeat base, repeat step
   int sop[7] = '{8'hA6, 8'hAE, 8'hAC, 8'hAA, 8'hA4, 8'h6C, 8'h6E};
   int scl[7] = '{`CL_SCMP, `CL_SSCAN, `CL_SLOAD, `CL_SSTORE, `CL_SMOVE, `CL_PIN, `CL_POUT};
   int sck[7] = '{22, 15, 12, 10, 14, 14, 14};
   int rb[7] = '{5, 5, 6, 6, 8, 8, 8};
   int ri[7] = '{22, 15, 11, 9, 8, 8, 8};
   initial begin
      forever #10 mclk = ~mclk;
   end
   lsj_decoder uut (.mclk(mclk), .arst_n(arst_n), .byte_valid(byte_valid),
      .byte_data(byte_data), .next_byte(next_byte), .narrow_bus(narrow_bus),
      .count_register(count_register), .byte_ready(byte_ready), .done(done),
      .op_class(op_class), .op_wide(op_wide), .op_dir(op_dir), .op_repeat(op_repeat),
      .op_repeat_z(op_repeat_z), .op_clocks(op_clocks), .op_iterations(op_iterations));
   prefetch_queue_model pf (.mclk(mclk), .byte_ready(byte_ready), .byte_valid(byte_valid),
      .byte_data(byte_data), .next_byte(next_byte));
   task chk(input logic [15:0] got, input logic [15:0] want);
      comparisons++;
      if (got !== want) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask
   task end_sim;
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task drain;
      int k;
      k = 0;
      while (exp_q.size() > 0 && k < 3000) begin
         @(negedge mclk);
         k++;
      end
      if (k == 3000) miscompares++;
   endtask
   // queue one instruction; inputs change only once the decoder is idle
   task run(input logic [7:0] p, op, m, input int cnt, nb, input logic [3:0] c, input int ck, it);
      if (cnt != count_register || nb != narrow_bus) drain;
      @(negedge mclk);
      count_register = cnt[15:0];
      narrow_bus = nb[0];
      rep_x = (p != 8'h00) && (p == 8'hF2 || c == `CL_SCMP || c == `CL_SSCAN);
      exp_q.push_back({op[0], op[1], rep_x, (p != 8'h00) && p[0], c, ck[15:0], it[15:0]});
      if (p != 8'h00) pf.push(p, 8'h00);
      pf.push(op, m);
   endtask
   always @(negedge mclk) begin
      if (done === 1'b1) begin
         if (exp_q.size() == 0) chk(16'hFFFF, 16'h0000);
         else begin
            e = exp_q.pop_front();
            chk(op_clocks, e[31:16]);
            chk({12'h000, op_class}, {12'h000, e[35:32]});
            chk(op_iterations, e[15:0]);
            chk({12'h000, op_wide, op_dir, op_repeat, op_repeat_z}, {12'h000, e[39:36]});
         end
      end
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         end_sim;
      end
   end
   initial begin
      void'($urandom(32'hCCAD3740));
      repeat (2) @(negedge mclk);
      arst_n = 1'b1;
      run(0, 8'h30, 8'hC0, 0, 0, `CL_XOR_RM, 3, 0);
      run(0, 8'h33, 8'h06, 0, 0, `CL_XOR_RM, 10, 0);
      run(0, 8'h80, 8'hF0, 0, 0, `CL_XOR_IMM, 4, 0);
      run(0, 8'h81, 8'h36, 0, 0, `CL_XOR_IMM, 16, 0);
      run(0, 8'h34, 8'h00, 0, 0, `CL_XOR_ACC, 3, 0);
      run(0, 8'h35, 8'h00, 0, 0, `CL_XOR_ACC, 4, 0);
      run(0, 8'hEB, 8'h00, 0, 0, `CL_JMP_DIR, 14, 0);
      run(0, 8'hE9, 8'h00, 0, 0, `CL_JMP_DIR, 14, 0);
      run(0, 8'hEA, 8'h00, 0, 0, `CL_JMP_DIR, 14, 0);
      run(0, 8'hFF, 8'hE0, 0, 0, `CL_JMP_IND, 11, 0);
      run(0, 8'hFF, 8'h26, 0, 0, `CL_JMP_IND, 17, 0);
      run(0, 8'hFF, 8'h2E, 0, 0, `CL_JMP_FAR_IND, 26, 0);
      for (int i = 0; i < 7; i++) run(0, sop[i][7:0], 0, 0, 0, scl[i][3:0], sck[i], 1);
      drain;
      $display("test single forms done");
      run(8'hF3, 8'hA4, 8'h00, 3, 0, `CL_SMOVE, 14, 1);
      run(8'hF2, 8'hA6, 8'h00, 3, 0, `CL_SCMP, 71, 3);
      run(8'hF2, 8'hAA, 8'h00, 0, 0, `CL_SSTORE, 6, 0);
      for (int i = 0; i < 7; i++) begin
         n = $urandom % 6;
         run(i < 2 ? 8'hF3 : 8'hF2, sop[i][7:0], 0, n, 0, scl[i][3:0], rb[i] + ri[i] * n, n);
      end
      drain;
      $display("test repeat forms done");
      run(0, 8'hA5, 8'h00, 0, 1, `CL_SMOVE, 22, 1);
      run(0, 8'hAD, 8'h00, 0, 1, `CL_SLOAD, 16, 1);
      run(0, 8'h31, 8'h06, 0, 1, `CL_XOR_RM, 18, 0);
      run(0, 8'hEB, 8'h00, 0, 1, `CL_JMP_DIR, 14, 0);
      run(8'hF2, 8'hA7, 8'h00, 2, 1, `CL_SCMP, 65, 2);
      drain;
      $display("test narrow bus done");
      end_sim;
   end
endmodule
`default_nettype wire
